// ==== gmc_defines.svh ====
`ifndef GMC_DEFINES_SVH
`define GMC_DEFINES_SVH

// Register offsets
`define GMC_OFF_CMD_L1 8'h04
`define GMC_OFF_READY_CODE 8'h05
`define GMC_OFF_GCI_MODE 8'h06
`define GMC_OFF_MON_CTRL 8'h07
`define GMC_OFF_MON_RX 8'h08
`define GMC_OFF_MON_TX 8'h09
`define GMC_OFF_MON_STATUS 8'h14
`define GMC_OFF_CI_IND 8'h15

// Reset values
`define GMC_RST_GCI_MODE 8'h00
`define GMC_RST_MON_CTRL 4'h0
`define GMC_RST_MON_DATA 8'hFF
`define GMC_RST_CMD_L1 4'hF
`define GMC_RST_READY_CODE 4'hC
`define GMC_RST_STATUS 4'h0

// GCI mode command fields
`define GMC_GCR_MAC 7
`define GMC_GCR_TLP 4
`define GMC_GCR_GCI_REMOTE_LOOPBACK 3
`define GMC_GCR_SPU 2
`define GMC_GCR_PD 1
`define GMC_GCR_GE 0

// Monitor control fields
`define GMC_MOC_MONITOR_RX_IRQ_EN 3
`define GMC_MOC_MRC 2
`define GMC_MOC_MONITOR_TX_IRQ_EN 1
`define GMC_MOC_MXC 0

// Monitor status fields
`define GMC_ST_MDR 3
`define GMC_ST_MER 2
`define GMC_ST_MDA 1
`define GMC_ST_MAB 0

// GCI frame layout, first bit on the line is bit 31
`define GMC_FR_LAST 5'd31
`define GMC_FR_B1 31:24
`define GMC_FR_B2 23:16
`define GMC_FR_MON 15:8
`define GMC_FR_D 7:6
`define GMC_FR_CI 5:2
`define GMC_FR_MR 1
`define GMC_FR_MX 0

// Indication and command codes
`define GMC_CI_DC 4'hF
`define GMC_CI_PU 4'h7
`define GMC_CI_AR 4'h8

// Frames without acknowledge before a monitor abort
`define GMC_ABORT_FRAMES 16

`endif

// ==== gmc_pkg.sv ====
`default_nettype none
package gmc_pkg;

  // Drive mode of the upstream data line
  typedef enum logic [3:0] {
    GMC_LINE_OFF = 4'b0001,
    GMC_LINE_LOW = 4'b0010,
    GMC_LINE_HIGH = 4'b0100,
    GMC_LINE_FRAME = 4'b1000
  } gmc_line_t;

  // Whole state of the block
  typedef struct packed {
    logic dcl_s1;
    logic dcl_s2;
    logic dcl_d;
    logic fsc_s1;
    logic fsc_s2;
    logic dd_s1;
    logic dd_s2;
    logic [4:0] bit_idx;
    logic [31:0] rx_sh;
    logic [31:0] tx_frame;
    logic up_out;
    logic up_oe;
    logic test_loopback;
    logic gci_remote_loopback;
    logic software_power_up;
    logic pd;
    logic ge;
    logic [3:0] monitor_control;
    logic [3:0] layer1_command_reg;
    logic [3:0] rc;
    logic [3:0] stat;
    logic [3:0] ci_ind;
    logic [7:0] monitor_transmit_data;
    logic [7:0] monitor_receive_data;
    logic [7:0] tx_wait;
    logic [7:0] rdata;
    logic tx_act;
    logic tx_sent;
    logic rx_act;
    logic prev_mx;
    logic indication_code_change_irq;
    logic rvalid;
  } gmc_state_t;

endpackage : gmc_pkg
`default_nettype wire

// ==== gmc_monitor_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gmc_defines.svh"

// How it works
// - GCI mode bit 7 shows monitor transmit busy
// - Test loopback joins lines, ignores downstream input
// - Remote loopback returns received 2B+D upstream
// - Power up alone drives upstream line low
// - Power down alone drives upstream line high
// - GCI enable turns off internal S/T layer
// - Receive enable gates byte and end flags
// - MR held high; first byte flagged only
// - Handshaked MR; every received byte flagged
// - Transmit enable gates acknowledge and abort flags
// - MX high, or handshaked when control set
// - GCI mode register at 06h, reset 00h
// - Monitor control at 07h, reset 00h
// - Monitor data registers reset to FFh
// - Read-to-clear monitor status, four event bits
// - Layer 1 command sent to transceiver in GCI
// - Decode idle 1111 and power up 0111
// - Ready code register, reset 0Ch, activation match
module gmc_monitor_control
  import gmc_pkg::*;
#(
  parameter int ABORT_FRAMES = `GMC_ABORT_FRAMES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register port from the bulk transfer engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // GCI bus
  input wire logic gci_clk_i,
  input wire logic gci_fsc_i,
  input wire logic downstream_data_line_i,
  output logic upstream_data_line_o,
  output logic upstream_data_line_oe_o,
  // Layer 1 status
  output logic gci_interface_on_o,
  output logic st_layer1_on_o,
  output logic monitor_tx_active_o,
  output logic indication_code_change_irq_o,
  output logic deactivation_confirm_o,
  output logic power_up_indication_o,
  output logic activation_ind_o
);

  // Constant reset image of the state
  function automatic gmc_state_t reset_value();
    gmc_state_t r;
    r = '0;
    r.monitor_transmit_data = `GMC_RST_MON_DATA;
    r.monitor_receive_data = `GMC_RST_MON_DATA;
    r.layer1_command_reg = `GMC_RST_CMD_L1;
    r.rc = `GMC_RST_READY_CODE;
    r.monitor_control = `GMC_RST_MON_CTRL;
    r.stat = `GMC_RST_STATUS;
    r.tx_frame = 32'hFFFFFFFF;
    r.prev_mx = 1'b1;
    r.up_out = 1'b1;
    return r;
  endfunction : reset_value

  // Tests one bit of the monitor control register
  function automatic logic moc_bit(input logic [3:0] moc, input int pos);
    moc_bit = moc[pos];
  endfunction : moc_bit

  localparam gmc_state_t ST_RESET = reset_value();
  localparam logic [7:0] ABORT_LAST = 8'(ABORT_FRAMES - 1);

  gmc_state_t st_ff;
  gmc_state_t nxt_st;
  logic dcl_rise;
  logic dcl_fall;
  logic rx_bit;
  logic [4:0] rx_idx;
  logic frame_end;
  logic [31:0] rx_full;
  logic rd_status;
  logic [4:0] tx_idx;
  gmc_line_t line_mode;

  // Link clock edges and received bit
  assign dcl_rise = st_ff.dcl_s2 & ~st_ff.dcl_d;
  assign dcl_fall = ~st_ff.dcl_s2 & st_ff.dcl_d;
  assign rx_bit = st_ff.test_loopback ? st_ff.up_out : st_ff.dd_s2;
  assign rx_idx = st_ff.fsc_s2 ? 5'd0 : 5'(st_ff.bit_idx + 5'd1);
  assign frame_end = dcl_rise & (rx_idx == `GMC_FR_LAST);
  assign rx_full = {st_ff.rx_sh[30:0], rx_bit};
  assign rd_status = reg_rd_i & (reg_addr_i == `GMC_OFF_MON_STATUS);
  assign tx_idx = 5'(`GMC_FR_LAST - 5'(st_ff.bit_idx + 5'd1));

  // Upstream line mode from power bits
  always_comb begin
    if (st_ff.software_power_up && !st_ff.pd) begin
      line_mode = GMC_LINE_LOW;
    end else if (!st_ff.software_power_up && st_ff.pd) begin
      line_mode = GMC_LINE_HIGH;
    end else if (st_ff.ge) begin
      line_mode = GMC_LINE_FRAME;
    end else begin
      line_mode = GMC_LINE_OFF;
    end
  end

  // Next state
  always_comb begin
    logic [3:0] sets;
    logic rmx;
    logic first;
    sets = 4'h0;
    rmx = rx_full[`GMC_FR_MX];
    first = 1'b0;
    nxt_st = st_ff;
    // Synchronisers and edge history
    nxt_st.dcl_s1 = gci_clk_i;
    nxt_st.dcl_s2 = st_ff.dcl_s1;
    nxt_st.dcl_d = st_ff.dcl_s2;
    nxt_st.fsc_s1 = gci_fsc_i;
    nxt_st.fsc_s2 = st_ff.fsc_s1;
    nxt_st.dd_s1 = downstream_data_line_i;
    nxt_st.dd_s2 = st_ff.dd_s1;
    nxt_st.indication_code_change_irq = 1'b0;
    nxt_st.rvalid = 1'b0;
    // Receive shift on rising link clock
    if (dcl_rise) begin
      nxt_st.bit_idx = rx_idx;
      nxt_st.rx_sh = rx_full;
    end
    // Frame complete: build next frame and run the monitor handshakes
    if (frame_end) begin
      nxt_st.tx_frame[`GMC_FR_B1] = st_ff.gci_remote_loopback ? rx_full[`GMC_FR_B1] : 8'hFF;
      nxt_st.tx_frame[`GMC_FR_B2] = st_ff.gci_remote_loopback ? rx_full[`GMC_FR_B2] : 8'hFF;
      nxt_st.tx_frame[`GMC_FR_D] = st_ff.gci_remote_loopback ? rx_full[`GMC_FR_D] : 2'b11;
      nxt_st.tx_frame[`GMC_FR_CI] = st_ff.layer1_command_reg;
      // Transmit side
      if (st_ff.tx_act && st_ff.tx_sent) begin
        if (!moc_bit(st_ff.monitor_control, `GMC_MOC_MXC)) begin
          nxt_st.tx_act = 1'b0;
        end else if (!rx_full[`GMC_FR_MR]) begin
          nxt_st.tx_act = 1'b0;
          sets[`GMC_ST_MDA] = moc_bit(st_ff.monitor_control, `GMC_MOC_MONITOR_TX_IRQ_EN);
        end else if (st_ff.tx_wait == ABORT_LAST) begin
          nxt_st.tx_act = 1'b0;
          sets[`GMC_ST_MAB] = moc_bit(st_ff.monitor_control, `GMC_MOC_MONITOR_TX_IRQ_EN);
        end else begin
          nxt_st.tx_wait = 8'(st_ff.tx_wait + 8'd1);
        end
      end else if (st_ff.tx_act) begin
        nxt_st.tx_sent = 1'b1;
      end
      nxt_st.tx_frame[`GMC_FR_MON] = nxt_st.tx_act ? st_ff.monitor_transmit_data : 8'hFF;
      nxt_st.tx_frame[`GMC_FR_MX] =
        ~(nxt_st.tx_act & moc_bit(st_ff.monitor_control, `GMC_MOC_MXC));
      // Receive side
      if (!rmx && st_ff.prev_mx) begin
        first = ~st_ff.rx_act;
        nxt_st.rx_act = 1'b1;
        nxt_st.monitor_receive_data = rx_full[`GMC_FR_MON];
        sets[`GMC_ST_MDR] = moc_bit(st_ff.monitor_control, `GMC_MOC_MONITOR_RX_IRQ_EN) &
          (moc_bit(st_ff.monitor_control, `GMC_MOC_MRC) | first);
      end else if (rmx && st_ff.prev_mx && st_ff.rx_act) begin
        nxt_st.rx_act = 1'b0;
        sets[`GMC_ST_MER] = moc_bit(st_ff.monitor_control, `GMC_MOC_MONITOR_RX_IRQ_EN);
      end
      nxt_st.prev_mx = rmx;
      nxt_st.tx_frame[`GMC_FR_MR] =
        moc_bit(st_ff.monitor_control, `GMC_MOC_MRC) ? rmx : 1'b1;
      // Indication code change
      if (st_ff.ge && (rx_full[`GMC_FR_CI] != st_ff.ci_ind)) begin
        nxt_st.ci_ind = rx_full[`GMC_FR_CI];
        nxt_st.indication_code_change_irq = 1'b1;
      end
    end
    // Upstream line: frame bits changed on falling link clock, fixed levels set at once
    case (line_mode)
      GMC_LINE_LOW: begin
        nxt_st.up_out = 1'b0;
        nxt_st.up_oe = 1'b1;
      end
      GMC_LINE_HIGH: begin
        nxt_st.up_out = 1'b1;
        nxt_st.up_oe = 1'b1;
      end
      GMC_LINE_FRAME: begin
        nxt_st.up_oe = 1'b1;
        if (dcl_fall) begin
          nxt_st.up_out = st_ff.tx_frame[tx_idx];
        end
      end
      default: begin
        nxt_st.up_out = 1'b1;
        nxt_st.up_oe = 1'b0;
      end
    endcase
    // Register writes
    if (reg_wr_i) begin
      if (reg_addr_i == `GMC_OFF_GCI_MODE) begin
        nxt_st.test_loopback = reg_wdata_i[`GMC_GCR_TLP];
        nxt_st.gci_remote_loopback = reg_wdata_i[`GMC_GCR_GCI_REMOTE_LOOPBACK];
        nxt_st.software_power_up = reg_wdata_i[`GMC_GCR_SPU];
        nxt_st.pd = reg_wdata_i[`GMC_GCR_PD];
        nxt_st.ge = reg_wdata_i[`GMC_GCR_GE];
      end else if (reg_addr_i == `GMC_OFF_MON_CTRL) begin
        nxt_st.monitor_control = reg_wdata_i[3:0];
      end else if (reg_addr_i == `GMC_OFF_MON_TX) begin
        nxt_st.monitor_transmit_data = reg_wdata_i;
        nxt_st.tx_act = 1'b1;
        nxt_st.tx_sent = 1'b0;
        nxt_st.tx_wait = 8'h00;
      end else if (reg_addr_i == `GMC_OFF_CMD_L1) begin
        nxt_st.layer1_command_reg = reg_wdata_i[3:0];
      end else if (reg_addr_i == `GMC_OFF_READY_CODE) begin
        nxt_st.rc = reg_wdata_i[3:0];
      end
    end
    // Status: read clears, a new event wins
    nxt_st.stat = (rd_status ? 4'h0 : st_ff.stat) | sets;
    // Register reads
    if (reg_rd_i) begin
      nxt_st.rvalid = 1'b1;
      if (reg_addr_i == `GMC_OFF_GCI_MODE) begin
        nxt_st.rdata = {st_ff.tx_act, 2'b00, st_ff.test_loopback, st_ff.gci_remote_loopback,
          st_ff.software_power_up, st_ff.pd, st_ff.ge};
      end else if (reg_addr_i == `GMC_OFF_MON_CTRL) begin
        nxt_st.rdata = {4'h0, st_ff.monitor_control};
      end else if (reg_addr_i == `GMC_OFF_MON_RX) begin
        nxt_st.rdata = st_ff.monitor_receive_data;
      end else if (reg_addr_i == `GMC_OFF_MON_TX) begin
        nxt_st.rdata = st_ff.monitor_transmit_data;
      end else if (reg_addr_i == `GMC_OFF_CMD_L1) begin
        nxt_st.rdata = {4'h0, st_ff.layer1_command_reg};
      end else if (reg_addr_i == `GMC_OFF_READY_CODE) begin
        nxt_st.rdata = {4'h0, st_ff.rc};
      end else if (reg_addr_i == `GMC_OFF_MON_STATUS) begin
        nxt_st.rdata = {4'h0, st_ff.stat};
      end else if (reg_addr_i == `GMC_OFF_CI_IND) begin
        nxt_st.rdata = {4'h0, st_ff.ci_ind};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign reg_rdata_o = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign upstream_data_line_o = st_ff.up_out;
  assign upstream_data_line_oe_o = st_ff.up_oe;
  assign gci_interface_on_o = st_ff.ge;
  assign st_layer1_on_o = ~st_ff.ge;
  assign monitor_tx_active_o = st_ff.tx_act;
  assign indication_code_change_irq_o = st_ff.indication_code_change_irq;
  assign deactivation_confirm_o = st_ff.ge & (st_ff.ci_ind == `GMC_CI_DC);
  assign power_up_indication_o = st_ff.ge & (st_ff.ci_ind == `GMC_CI_PU);
  assign activation_ind_o = st_ff.ge & (st_ff.ci_ind == st_ff.rc);

  // Checks
  property p_mac_read;
    @(posedge mclk_i) disable iff (!resetn_i)
    (reg_rd_i && reg_addr_i == `GMC_OFF_GCI_MODE) |=> reg_rdata_o[7] == $past(st_ff.tx_act) && reg_rvalid_o;
  endproperty
  a_mac_read: assert property (p_mac_read) else $error("busy flag misread");

  property p_test_loop;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_ff.test_loopback && dcl_rise) |=> st_ff.rx_sh[0] == $past(st_ff.up_out);
  endproperty
  a_test_loop: assert property (p_test_loop) else $error("test loopback not looped");

  property p_remote_loop;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_ff.gci_remote_loopback && frame_end) |=> st_ff.tx_frame[`GMC_FR_B1] == $past(rx_full[`GMC_FR_B1])
      && st_ff.tx_frame[`GMC_FR_D] == $past(rx_full[`GMC_FR_D]);
  endproperty
  a_remote_loop: assert property (p_remote_loop) else $error("remote loopback lost data");

  property p_power_low;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_ff.software_power_up && !st_ff.pd)[*2] |-> !upstream_data_line_o && upstream_data_line_oe_o;
  endproperty
  a_power_low: assert property (p_power_low) else $error("upstream not pulled low");

  property p_power_high;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!st_ff.software_power_up && st_ff.pd)[*2] |-> upstream_data_line_o && upstream_data_line_oe_o;
  endproperty
  a_power_high: assert property (p_power_high) else $error("upstream not driven high");

  property p_layer1_off;
    @(posedge mclk_i) disable iff (!resetn_i)
    gci_interface_on_o |-> !st_layer1_on_o ##1 upstream_data_line_oe_o;
  endproperty
  a_layer1_off: assert property (p_layer1_off) else $error("S/T layer on with GCI");

  property p_rx_masked;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!st_ff.monitor_control[`GMC_MOC_MONITOR_RX_IRQ_EN] && !rd_status) |=> st_ff.stat[3:2] == $past(st_ff.stat[3:2]);
  endproperty
  a_rx_masked: assert property (p_rx_masked) else $error("masked receive flag set");

  property p_tx_masked;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!st_ff.monitor_control[`GMC_MOC_MONITOR_TX_IRQ_EN] && !rd_status) |=> st_ff.stat[1:0] == $past(st_ff.stat[1:0]);
  endproperty
  a_tx_masked: assert property (p_tx_masked) else $error("masked transmit flag set");

  property p_mr_high;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!st_ff.monitor_control[`GMC_MOC_MRC] && frame_end) |=> st_ff.tx_frame[`GMC_FR_MR];
  endproperty
  a_mr_high: assert property (p_mr_high) else $error("MR bit not held high");

  property p_mx_high;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!st_ff.monitor_control[`GMC_MOC_MXC] && frame_end) |=> st_ff.tx_frame[`GMC_FR_MX];
  endproperty
  a_mx_high: assert property (p_mx_high) else $error("MX bit not held high");

  property p_tx_start;
    @(posedge mclk_i) disable iff (!resetn_i)
    (reg_wr_i && reg_addr_i == `GMC_OFF_MON_TX) |=> monitor_tx_active_o && st_ff.monitor_transmit_data == $past(reg_wdata_i);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit not started");

  property p_status_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
    (rd_status && !frame_end) |=> st_ff.stat == 4'h0 && reg_rvalid_o && reg_rdata_o == {4'h0, $past(st_ff.stat)};
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

endmodule : gmc_monitor_control
`default_nettype wire

// ==== gmc_xcvr_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Transceiver on the far side of the GCI bus
module gmc_xcvr_model (
  // GCI bus
  output logic gci_clk_o,
  output logic gci_fsc_o,
  output logic dd_o,
  input wire logic up_i
);
  // Link clock stands still low between frames
  initial begin
    gci_clk_o = 1'h0;
    gci_fsc_o = 1'h0;
    dd_o = 1'h1;
  end
  // One frame, bit 31 first, upstream sampled at each rise
  task automatic send_frame(input logic [31:0] f, output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      gci_clk_o = 1'h0;
      dd_o = f[i];
      gci_fsc_o = (i == 31);
      #80;
      gci_clk_o = 1'h1;
      r[i] = up_i;
      #80;
    end
    gci_clk_o = 1'h0;
    gci_fsc_o = 1'h0;
    dd_o = ~dd_o; // Released line does not keep its last bit
  endtask : send_frame
endmodule : gmc_xcvr_model
`default_nettype wire

// ==== tb_gmc_monitor_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_gmc_monitor_control
  import gmc_pkg::*;
;
  logic mclk_i, resetn_i, reg_wr_i, reg_rd_i, rvalid, gclk, fsc, dd, up, up_oe, up_w;
  logic ge_o, st_o, busy_o, irq_o, dc_o, pu_o, act_o;
  logic [7:0] addr, wdata, rdata, v;
  logic [31:0] cap;
  logic [7:0] exp_q[$];
  logic [7:0] ra[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h14, 8'h30};
  logic [7:0] re[8] = '{8'h0F, 8'h0C, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [3:0] codes[3] = '{4'hF, 4'h7, 4'hC};
  int n_errors = 0;
  int comparisons = 0;
  int n_irq = 0;
  int k;
  int seed = 32'h5e7f839b;

  // Pull-up on the upstream line when released
  assign up_w = up_oe ? up : 1'h1;

  gmc_monitor_control #(.ABORT_FRAMES(4)) u_gmc_monitor_control (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(addr), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .gci_clk_i(gclk), .gci_fsc_i(fsc), .downstream_data_line_i(dd),
    .upstream_data_line_o(up), .upstream_data_line_oe_o(up_oe),
    .gci_interface_on_o(ge_o), .st_layer1_on_o(st_o), .monitor_tx_active_o(busy_o),
    .indication_code_change_irq_o(irq_o), .deactivation_confirm_o(dc_o),
    .power_up_indication_o(pu_o), .activation_ind_o(act_o)
  );

  gmc_xcvr_model u_gmc_xcvr_model (.gci_clk_o(gclk), .gci_fsc_o(fsc), .dd_o(dd), .up_i(up_w));

  // Clock, 20 ns
  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    reg_wr_i = 1'h1;
    @(negedge mclk_i);
    reg_wr_i = 1'h0;
  endtask : wr

  // Read strobe, expected value noted in the queue
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    addr = a;
    reg_rd_i = 1'h1;
    exp_q.push_back(e);
    @(negedge mclk_i);
    reg_rd_i = 1'h0;
    @(negedge mclk_i);
  endtask : rd

  task automatic fr(input logic [31:0] f);
    u_gmc_xcvr_model.send_frame(f, cap);
    #100;
  endtask : fr

  function automatic logic [31:0] mk(input logic [7:0] mon, input logic [3:0] ci, input logic mr, input logic mx);
    return {16'hFFFF, mon, 2'h3, ci, mr, mx};
  endfunction : mk

  // Read answers taken off the queue
  always @(negedge mclk_i) begin
    if (rvalid === 1'h1) begin
      if (exp_q.size() == 0) begin
        check(rdata, 8'hXX);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  // Count indication change pulses
  always @(posedge mclk_i) begin
    if (irq_o === 1'h1) begin
      n_irq <= n_irq + 1;
    end
  end

  task automatic stop_test;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Run limit
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_errors++;
    stop_test();
  end

  initial begin
    resetn_i = 1'h0;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'h1;
    // Reset values and unmapped read
    check({ge_o, st_o, up_oe, busy_o, dc_o, pu_o, act_o}, 7'h20);
    for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
    $display("test reset done");
    // Power levels and read-only bits
    wr(8'h06, 8'hFB);
    rd(8'h06, 8'h1B);
    check({ge_o, st_o, up, up_oe}, 4'hB);
    wr(8'h06, 8'h05); // Never both power bits
    @(negedge mclk_i);
    check({up, up_oe}, 2'h1);
    wr(8'h06, 8'h01);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h0F);
    wr(8'h07, 8'h00);
    $display("test power done");
    // Indications, ready code, activate request
    for (int i = 0; i < 3; i++) begin
      k = n_irq;
      fr(mk(8'hFF, codes[i], 1'h1, 1'h1));
      fr(mk(8'hFF, codes[i], 1'h1, 1'h1));
      check({dc_o, pu_o, act_o}, 3'h4 >> i);
      if (i > 0) check(n_irq - k, 1);
      if (i == 1) wr(8'h04, 8'h08);
    end
    rd(8'h15, 8'h0C);
    check(cap[5:0], 6'h23);
    $display("test indication done");
    // Receive flags masked, then enabled with handshake
    for (int i = 0; i < 2; i++) begin
      wr(8'h07, i ? 8'h0C : 8'h04);
      fr(mk(8'h3C + i, 4'hC, 1'h1, 1'h0));
      fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
      if (i) check(cap[1], 1'h0);
      fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
      rd(8'h14, i ? 8'h0C : 8'h00);
    end
    rd(8'h08, 8'h3D);
    rd(8'h14, 8'h00);
    // Two bytes with MR held high, only the first flagged
    wr(8'h07, 8'h08);
    fr(mk(8'h5A, 4'hC, 1'h1, 1'h0));
    rd(8'h14, 8'h08);
    fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    fr(mk(8'hA5, 4'hC, 1'h1, 1'h0));
    check(cap[1], 1'h1);
    rd(8'h14, 8'h00);
    repeat (2) fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    rd(8'h14, 8'h04);
    rd(8'h08, 8'hA5);
    $display("test receive done");
    // Transmit with acknowledge, then abort
    wr(8'h07, 8'h03);
    rd(8'h06, 8'h01); // Idle before a new byte
    v = 8'($random(seed));
    wr(8'h09, v);
    check(busy_o, 1'h1);
    rd(8'h06, 8'h81);
    rd(8'h09, v);
    fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    check({cap[15:8], cap[0]}, {v, 1'h0});
    fr(mk(8'hFF, 4'hC, 1'h0, 1'h1));
    rd(8'h14, 8'h02);
    wr(8'h09, ~v);
    repeat (6) fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    rd(8'h14, 8'h01);
    wr(8'h07, 8'h00);
    wr(8'h09, v);
    repeat (3) fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    check({busy_o, cap[0]}, 2'h1);
    $display("test transmit done");
    // Remote loopback of 2B+D
    wr(8'h06, 8'h09);
    fr({v, ~v, 8'hFF, 2'h2, 4'hC, 2'h3});
    fr(mk(8'hFF, 4'hC, 1'h1, 1'h1));
    check({cap[31:16], cap[7:6]}, {v, ~v, 2'h2});
    $display("test remote loopback done");
    // Test loopback: own code received, downstream ignored
    wr(8'h04, 8'h07);
    wr(8'h06, 8'h11);
    repeat (3) fr(mk(8'hFF, 4'hF, 1'h1, 1'h1));
    check(pu_o, 1'h1);
    rd(8'h15, 8'h07);
    $display("test loopback done");
    check(exp_q.size(), 0);
    stop_test();
  end
endmodule : tb_gmc_monitor_control
`default_nettype wire
